// file: rtl/susp_pkg.sv
// constants and types shared by the suspend control block
package susp_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   // register offsets (byte addresses, one word each)
   localparam logic [ADDR_W-1:0] SUSPEND_CONTROL_OFS = 4'h0;
   localparam logic [ADDR_W-1:0] PORT_FUNCTION_CONTROL_3_OFS = 4'h4;
   localparam logic [ADDR_W-1:0] BUS_STATE_OFS = 4'h8;
   // suspend_control_reg fields
   localparam int SUSPEND_OUTPUT_ENABLE_BIT = 0;
   localparam int SUSPEND_CHANGE_INT_ENABLE_BIT = 1;
   localparam int SUSPEND_CHANGE_FLAG_BIT = 2;
   localparam int SUSPEND_STATE_MONITOR_BIT = 3;
   // port_function_control_3 fields
   localparam int RECOVER_INT_ENABLE_BIT = 0;
   localparam int RECOVER_FLAG_BIT = 1;
   // bus state register fields
   localparam int LINK_CLOCK_SEEN_BIT = 0;
   localparam int LINE_IDLE_BIT = 1;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
   // timing
   localparam int CLK_HZ = 20_000_000;
   localparam int IDLE_TIME_US = 3000;
   localparam int IDLE_CYCLES = (IDLE_TIME_US * (CLK_HZ / 1_000_000));
   localparam int OSC_STABLE_US = 100;
   localparam int OSC_STABLE_CYCLES = (OSC_STABLE_US * (CLK_HZ / 1_000_000));
   localparam int CNT_W = 20;
   localparam int SYNC_STAGES = 2;
   typedef enum logic [1:0]
   {
      ST_ACTIVE = 2'b00,
      ST_SUSPENDED = 2'b01,
      ST_WAKING = 2'b11
   } link_state_e;
endpackage

// file: rtl/susp_if.sv
// signals passed between the suspend top and its helper modules
`timescale 1ns/10ps
interface susp_if;
   logic line_idle;
   logic link_clk_edge;
   logic suspended;
   logic wake_done;
   modport sync_side (output line_idle, output link_clk_edge);
   modport tracker_side (input line_idle, output suspended, output wake_done);
   modport top_side (input line_idle, input link_clk_edge, input suspended, input wake_done);
endinterface

// file: rtl/pin_sync.sv
// double-flop synchroniser for the idle line and link clock, with link clock edge pulse
`timescale 1ns/10ps
module pin_sync
   import susp_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic line_idle_pin,
   input wire logic phy_supplied_clock,
   susp_if.sync_side sync
);
   typedef struct packed
   {
      logic [SYNC_STAGES-1:0] idle_sh;
      logic [SYNC_STAGES-1:0] clk_sh;
      logic clk_last;
      logic edge_p;
   } sync_s;
   sync_s st_r;
   sync_s st_nxt;
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.idle_sh = {st_r.idle_sh[0], line_idle_pin};
      st_nxt.clk_sh = {st_r.clk_sh[0], phy_supplied_clock};
      st_nxt.clk_last = st_r.clk_sh[1];
      st_nxt.edge_p = st_r.clk_sh[1] & ~st_r.clk_last;
   end
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end
   assign sync.line_idle = st_r.idle_sh[1];
   assign sync.link_clk_edge = st_r.edge_p;
endmodule

// file: rtl/idle_tracker.sv
// idle timer: raises internal suspend after long idle, drops it on resume, times wake-up
`timescale 1ns/10ps
module idle_tracker
   import susp_pkg::*;
#(
   parameter int IDLE_LIMIT = IDLE_CYCLES,
   parameter int OSC_LIMIT = OSC_STABLE_CYCLES
)
(
   input wire logic clk,
   input wire logic srst,
   susp_if.tracker_side trk
);
   typedef struct packed
   {
      link_state_e state;
      logic [CNT_W-1:0] cnt;
      logic wake_done;
   } trk_s;
   trk_s st_r;
   trk_s st_nxt;
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.wake_done = 1'b0;
      unique case (st_r.state)
         ST_ACTIVE:
         begin
            if (!trk.line_idle)
            begin
               st_nxt.cnt = '0;
            end
            else if (st_r.cnt == CNT_W'(IDLE_LIMIT - 1))
            begin
               st_nxt.state = ST_SUSPENDED;
               st_nxt.cnt = '0;
            end
            else
            begin
               st_nxt.cnt = st_r.cnt + 1'b1;
            end
         end
         ST_SUSPENDED:
         begin
            // resume is seen on the line level alone, no link clock needed
            if (!trk.line_idle)
            begin
               st_nxt.state = ST_WAKING;
               st_nxt.cnt = '0;
            end
         end
         ST_WAKING:
         begin
            if (st_r.cnt == CNT_W'(OSC_LIMIT - 1))
            begin
               st_nxt.state = ST_ACTIVE;
               st_nxt.cnt = '0;
               st_nxt.wake_done = 1'b1;
            end
            else
            begin
               st_nxt.cnt = st_r.cnt + 1'b1;
            end
         end
         default:
         begin
            st_nxt.state = ST_ACTIVE;
            st_nxt.cnt = '0;
         end
      endcase
   end
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         st_r <= '{state: ST_ACTIVE, cnt: '0, wake_done: 1'b0};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end
   assign trk.suspended = (st_r.state == ST_SUSPENDED);
   assign trk.wake_done = st_r.wake_done;
endmodule

// file: rtl/usb_suspend_control.sv
// suspend control top: registers, suspend pin, change and recover interrupts
//
// What this block does
// - suspend output enable at 0 holds suspend_out_n high.
// - long bus idle raises internal suspend; masked pin stays unchanged.
// - with change enable set, every suspend change sets flag and interrupt.
// - change interrupt fires on suspend exit as well as entry.
// - monitor bit reads the current internal suspend state.
// - software stops DMA, then enables output; pin goes low.
// - internal suspend drops on bus resume without the link clock.
// - bus leaving idle while suspended sets the recover flag.
// - recover request is detected on clk through the synchroniser and cancels standby.
// - on recovery pin negates, wake asserted on a new enabled recover interrupt, clock after stabilisation.
// - module request is the OR of all flag bits.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/10ps
module usb_suspend_control
   import susp_pkg::*;
#(
   parameter int IDLE_LIMIT = IDLE_CYCLES,
   parameter int OSC_LIMIT = OSC_STABLE_CYCLES
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [susp_pkg::ADDR_W-1:0] addr,
   input wire logic [susp_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [susp_pkg::DATA_W-1:0] rdata,
   input wire logic line_idle_pin,
   input wire logic phy_supplied_clock,
   output logic suspend_out_n,
   output logic suspend_change_irq,
   output logic suspend_recover_irq,
   output logic module_irq,
   output logic standby_wake,
   output logic clock_release
);
   typedef struct packed
   {
      logic [DATA_W-1:0] rdata;
      logic suspend_output_enable;
      logic suspend_change_int_enable;
      logic suspend_change_flag;
      logic recover_int_enable;
      logic recover_flag;
      logic susp_last;
      logic link_seen;
      logic pin_n;
      logic change_irq;
      logic recover_irq;
      logic mod_irq;
      logic wake;
      logic clk_rel;
   } top_s;
   top_s st_r;
   top_s st_nxt;
   susp_if sif ();
   pin_sync u_sync
   (
      .clk(clk),
      .srst(srst),
      .line_idle_pin(line_idle_pin),
      .phy_supplied_clock(phy_supplied_clock),
      .sync(sif.sync_side)
   );
   idle_tracker #(.IDLE_LIMIT(IDLE_LIMIT), .OSC_LIMIT(OSC_LIMIT)) u_trk
   (
      .clk(clk),
      .srst(srst),
      .trk(sif.tracker_side)
   );
   logic susp_change;
   logic susp_exit;
   always_comb
   begin
      susp_change = sif.suspended ^ st_r.susp_last;
      susp_exit = st_r.susp_last & ~sif.suspended;
   end
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.susp_last = sif.suspended;
      st_nxt.rdata = READ_ZERO;
      // word-wide writes only; lanes are not split
      if (wr)
      begin
         unique case (addr)
            SUSPEND_CONTROL_OFS:
            begin
               st_nxt.suspend_output_enable = wdata[SUSPEND_OUTPUT_ENABLE_BIT];
               st_nxt.suspend_change_int_enable = wdata[SUSPEND_CHANGE_INT_ENABLE_BIT];
               if (!wdata[SUSPEND_CHANGE_FLAG_BIT])
               begin
                  st_nxt.suspend_change_flag = 1'b0;
               end
            end
            PORT_FUNCTION_CONTROL_3_OFS:
            begin
               st_nxt.recover_int_enable = wdata[RECOVER_INT_ENABLE_BIT];
               if (!wdata[RECOVER_FLAG_BIT])
               begin
                  st_nxt.recover_flag = 1'b0;
               end
            end
            BUS_STATE_OFS:
            begin
               if (wdata[LINK_CLOCK_SEEN_BIT])
               begin
                  st_nxt.link_seen = 1'b0;
               end
            end
            default:
            begin
            end
         endcase
      end
      // set wins over a clear in the same cycle
      if (susp_change && st_r.suspend_change_int_enable)
      begin
         st_nxt.suspend_change_flag = 1'b1;
      end
      // a link clock edge beats a clear written in the same cycle
      if (sif.link_clk_edge)
      begin
         st_nxt.link_seen = 1'b1;
      end
      // exit from suspend is recognised from the line level, no link edges needed
      if (susp_exit)
      begin
         st_nxt.recover_flag = 1'b1;
      end
      if (rd)
      begin
         unique case (addr)
            SUSPEND_CONTROL_OFS:
            begin
               st_nxt.rdata[SUSPEND_OUTPUT_ENABLE_BIT] = st_r.suspend_output_enable;
               st_nxt.rdata[SUSPEND_CHANGE_INT_ENABLE_BIT] = st_r.suspend_change_int_enable;
               st_nxt.rdata[SUSPEND_CHANGE_FLAG_BIT] = st_r.suspend_change_flag;
               st_nxt.rdata[SUSPEND_STATE_MONITOR_BIT] = sif.suspended;
            end
            PORT_FUNCTION_CONTROL_3_OFS:
            begin
               st_nxt.rdata[RECOVER_INT_ENABLE_BIT] = st_r.recover_int_enable;
               st_nxt.rdata[RECOVER_FLAG_BIT] = st_r.recover_flag;
            end
            BUS_STATE_OFS:
            begin
               st_nxt.rdata[LINK_CLOCK_SEEN_BIT] = st_r.link_seen;
               st_nxt.rdata[LINE_IDLE_BIT] = sif.line_idle;
            end
            default:
            begin
            end
         endcase
      end
      // pin low only when enabled and suspended; masked high otherwise
      st_nxt.pin_n = ~(st_nxt.suspend_output_enable & sif.suspended);
      st_nxt.change_irq = st_nxt.suspend_change_flag & st_nxt.suspend_change_int_enable;
      st_nxt.recover_irq = st_nxt.recover_flag & st_nxt.recover_int_enable;
      st_nxt.mod_irq = st_nxt.suspend_change_flag | st_nxt.recover_flag;
      // wake request held from recover until stabilisation finishes
      // raised once on a new recover request while the clock is held back,
      // so a still-pending request does not restart the wake after release
      if (st_nxt.recover_irq && !st_r.recover_irq && !st_r.clk_rel)
      begin
         st_nxt.wake = 1'b1;
      end
      if (sif.wake_done)
      begin
         st_nxt.wake = 1'b0;
         st_nxt.clk_rel = 1'b1;
      end
      else if (sif.suspended)
      begin
         st_nxt.clk_rel = 1'b0;
      end
   end
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         st_r <= '0;
         st_r.pin_n <= 1'b1;
         st_r.clk_rel <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end
   assign rdata = st_r.rdata;
   assign suspend_out_n = st_r.pin_n;
   assign suspend_change_irq = st_r.change_irq;
   assign suspend_recover_irq = st_r.recover_irq;
   assign module_irq = st_r.mod_irq;
   assign standby_wake = st_r.wake;
   assign clock_release = st_r.clk_rel;
endmodule

// file: verif/usb_suspend_control_properties.sv
// port assertions for the suspend control block
`timescale 1ns/10ps
module susp_checker
   import susp_pkg::*;
#(
   parameter int IDLE_LIMIT = 20,
   parameter int OSC_LIMIT = 5
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [susp_pkg::ADDR_W-1:0] addr,
   input wire logic [susp_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [susp_pkg::DATA_W-1:0] rdata,
   input wire logic line_idle_pin,
   input wire logic suspend_out_n,
   input wire logic suspend_change_irq,
   input wire logic suspend_recover_irq,
   input wire logic module_irq,
   input wire logic standby_wake,
   input wire logic clock_release
);
   localparam int OSC_HI = OSC_LIMIT + 4;
   logic oe_r;
   logic ce_r;
   logic re_r;
   int idle_r;
   // shadow of the enables and a raw idle run length
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         oe_r <= 1'b0;
         ce_r <= 1'b0;
         re_r <= 1'b0;
         idle_r <= 0;
      end
      else
      begin
         if (wr && addr == SUSPEND_CONTROL_OFS)
         begin
            oe_r <= wdata[SUSPEND_OUTPUT_ENABLE_BIT];
            ce_r <= wdata[SUSPEND_CHANGE_INT_ENABLE_BIT];
         end
         if (wr && addr == PORT_FUNCTION_CONTROL_3_OFS)
         begin
            re_r <= wdata[RECOVER_INT_ENABLE_BIT];
         end
         idle_r <= line_idle_pin ? idle_r + 1 : 0;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   chk_pin_masked: assert property (!oe_r |-> suspend_out_n)
      else $error("pin low while masked");
   chk_pin_cause: assert property ($fell(suspend_out_n) |-> oe_r && idle_r >= IDLE_LIMIT)
      else $error("pin low too early");
   chk_change_gate: assert property (suspend_change_irq |-> ce_r || $past(ce_r))
      else $error("change irq while disabled");
   chk_recover_gate: assert property (suspend_recover_irq |-> re_r || $past(re_r))
      else $error("recover irq while disabled");
   chk_irq_or: assert property (suspend_change_irq || suspend_recover_irq |-> module_irq)
      else $error("module irq missing");
   chk_resume_pin: assert property ($fell(line_idle_pin) |-> ##[1:6] suspend_out_n)
      else $error("pin not released on resume");
   chk_wake_release: assert property ($rose(standby_wake) |-> !clock_release ##[1:OSC_HI] clock_release)
      else $error("clock release timing wrong");
   chk_rd_quiet: assert property (!$past(rd) |-> rdata == READ_ZERO)
      else $error("read data outside read slot");
endmodule

bind usb_suspend_control susp_checker #(.IDLE_LIMIT(IDLE_LIMIT), .OSC_LIMIT(OSC_LIMIT)) susp_checker_inst
(
   .clk, .srst, .addr, .wdata, .wr, .rd, .rdata, .line_idle_pin, .suspend_out_n,
   .suspend_change_irq, .suspend_recover_irq, .module_irq, .standby_wake, .clock_release
);

// file: verif/phy_model.sv
// transceiver model: bus idle line and link clock
`timescale 1ns/10ps
module phy_model
(
   input wire logic suspend_out_n,
   input wire logic idle_cmd,
   output logic line_idle_pin,
   output logic phy_supplied_clock
);
   initial phy_supplied_clock = 1'b0;
   assign line_idle_pin = idle_cmd;
   // link clock stands still while the suspend pin is low
   always #200
      if (suspend_out_n)
         phy_supplied_clock = ~phy_supplied_clock;
endmodule

// file: verif/usb_suspend_control_tb.sv
// self-checking bench for the suspend control block
`timescale 1ns/10ps
module usb_suspend_control_tb;
   import susp_pkg::*;
   localparam int IDLE_N = 20;
   localparam int OSC_N = 40;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_q = 1'b0;
   logic idle_cmd = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic line_idle_pin, phy_supplied_clock, suspend_out_n, suspend_change_irq;
   logic suspend_recover_irq, module_irq, standby_wake, clock_release;
   logic [5:0] pins;
   logic [DATA_W-1:0] exp_q[$];
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;
   int seed = 32'hE2E8;
   assign pins = {suspend_out_n, suspend_change_irq, suspend_recover_irq, module_irq,
      standby_wake, clock_release};
   always #25 clk = ~clk;
   usb_suspend_control #(.IDLE_LIMIT(IDLE_N), .OSC_LIMIT(OSC_N)) usb_suspend_control_inst
   (
      .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .line_idle_pin(line_idle_pin), .phy_supplied_clock(phy_supplied_clock),
      .suspend_out_n(suspend_out_n), .suspend_change_irq(suspend_change_irq),
      .suspend_recover_irq(suspend_recover_irq), .module_irq(module_irq),
      .standby_wake(standby_wake), .clock_release(clock_release)
   );
   phy_model phy_model_inst
   (
      .suspend_out_n(suspend_out_n), .idle_cmd(idle_cmd),
      .line_idle_pin(line_idle_pin), .phy_supplied_clock(phy_supplied_clock)
   );
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      exp_q.push_back(d);
      @(posedge clk);
      rd <= 1'b0;
   endtask
   // read data stand in the cycle after the strobe
   always @(posedge clk)
   begin
      rd_q <= rd;
      cycles <= cycles + 1;
      if (rd_q)
         check(rdata, exp_q.pop_front());
      if (cycles == 2000)
      begin
         miscompares++;
         test_done();
      end
   end
   initial
   begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      check({26'h0, pins}, 32'h21);
      rd_reg(SUSPEND_CONTROL_OFS, 32'h0);
      rd_reg(PORT_FUNCTION_CONTROL_3_OFS, 32'h0);
      wr_reg(4'hC, $random(seed));
      rd_reg(4'hC, 32'h0);
      wr_reg(SUSPEND_CONTROL_OFS, 32'h0);
      wr_reg(SUSPEND_CONTROL_OFS, 32'h2);
      wr_reg(PORT_FUNCTION_CONTROL_3_OFS, 32'h0);
      wr_reg(PORT_FUNCTION_CONTROL_3_OFS, 32'h1);
      idle_cmd <= 1'b1;
      repeat (IDLE_N + 8) @(posedge clk);
      check({26'h0, pins}, 32'h34);
      rd_reg(SUSPEND_CONTROL_OFS, 32'hE);
      rd_reg(BUS_STATE_OFS, 32'h3);
      wr_reg(SUSPEND_CONTROL_OFS, 32'h2);
      wr_reg(SUSPEND_CONTROL_OFS, 32'h3);
      // software sleeps here: no register traffic until the bus resumes
      repeat (3) @(posedge clk);
      check({26'h0, pins}, 32'h00);
      idle_cmd <= 1'b0;
      repeat (6) @(posedge clk);
      check({26'h0, pins}, 32'h3E);
      repeat (OSC_N) @(posedge clk);
      check({26'h0, pins}, 32'h3D);
      wr_reg(SUSPEND_CONTROL_OFS, 32'h6);
      rd_reg(PORT_FUNCTION_CONTROL_3_OFS, 32'h3);
      wr_reg(PORT_FUNCTION_CONTROL_3_OFS, 32'h1);
      repeat (2) @(posedge clk);
      check({26'h0, pins}, 32'h35);
      rd_reg(SUSPEND_CONTROL_OFS, 32'h6);
      wr_reg(SUSPEND_CONTROL_OFS, 32'h2);
      wr_reg(PORT_FUNCTION_CONTROL_3_OFS, 32'h0);
      repeat (2) @(posedge clk);
      check({26'h0, pins}, 32'h21);
      rd_reg(BUS_STATE_OFS, 32'h1);
      repeat (2) @(posedge clk);
      test_done();
   end
endmodule
